/* File: asrc_ctrl.v */
// Host-side controller for an asynchronous 16-bit SRAM with byte lanes.
// Assumes the memory pins are wired directly; data pins are split in/out/enable.
`timescale 1ns/1ps
`include "asrc_consts.vh"

module asrc_ctrl #(
    parameter AW = 21
) (
    ref_clk,
    rst_n,
    byte_mode,
    req_valid,
    req_write,
    req_addr,
    req_lanes,
    req_wdata,
    req_ready,
    rsp_valid,
    rsp_rdata,
    mem_addr,
    extra_address_bit,
    select_n,
    select_hi,
    write_n,
    out_gate_n,
    upper_lane_n,
    lower_lane_n,
    data_pins_in,
    data_pins_out,
    data_pins_oe_n
);
    input wire ref_clk;
    input wire rst_n;
    input wire byte_mode;
    input wire req_valid;
    input wire req_write;
    input wire [AW:0] req_addr;
    input wire [1:0] req_lanes;
    input wire [15:0] req_wdata;
    output wire req_ready;
    output reg rsp_valid;
    output reg [15:0] rsp_rdata;
    output reg [AW-1:0] mem_addr;
    output reg extra_address_bit;
    output reg select_n;
    output reg select_hi;
    output reg write_n;
    output reg out_gate_n;
    output reg upper_lane_n;
    output reg lower_lane_n;
    input wire [15:0] data_pins_in;
    output reg [15:0] data_pins_out;
    output reg data_pins_oe_n;

    // ----------------------------------------------------------------
    // Timing counts
    // ----------------------------------------------------------------
    // Read waits the longest access time so any of address, select, gate or lane paths is met.
    localparam integer RD_NUM = `ASRC_ATLEAST1(`ASRC_CYC(`ASRC_T_AA_NS));
    localparam integer WR_NUM = `ASRC_ATLEAST1(`ASRC_CYC(`ASRC_T_AW_NS));
    localparam integer HZ_NUM = `ASRC_ATLEAST1(`ASRC_CYC(`ASRC_T_HZ_NS));
    localparam integer WC_NUM = `ASRC_ATLEAST1(`ASRC_CYC(`ASRC_T_WC_NS));
    // The counter is five bits wide; every count above fits, so the slices drop only zero bits.
    localparam [4:0] RD_CYC = RD_NUM[4:0];
    localparam [4:0] WR_CYC = WR_NUM[4:0];
    localparam [4:0] HZ_CYC = HZ_NUM[4:0];
    localparam [4:0] WC_CYC = WC_NUM[4:0];

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_READ = 3'h1;
    localparam [2:0] ST_WRITE = 3'h2;
    localparam [2:0] ST_WEND = 3'h3;
    localparam [2:0] ST_TURN = 3'h4;

    reg [2:0] state_q;
    reg [4:0] cnt_q;
    reg [15:0] din_s1_q;
    reg [15:0] din_s2_q;

    assign req_ready = (state_q == ST_IDLE);

    // ----------------------------------------------------------------
    // Data pin synchroniser
    // ----------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            din_s1_q <= 16'h0000;
            din_s2_q <= 16'h0000;
        end else begin
            din_s1_q <= data_pins_in;
            din_s2_q <= din_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // Access sequencer
    // ----------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
            mem_addr <= {AW{1'b0}};
            extra_address_bit <= 1'b0;
            select_n <= 1'b1;
            select_hi <= 1'b0;
            write_n <= 1'b1;
            out_gate_n <= 1'b1;
            upper_lane_n <= 1'b1;
            lower_lane_n <= 1'b1;
            data_pins_out <= 16'h0000;
            data_pins_oe_n <= 1'b1;
        end else begin
            rsp_valid <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (req_valid && (req_lanes != 2'b00 || byte_mode)) begin
                        // Address before or with the strobes; no change until the access ends.
                        mem_addr <= req_addr[AW-1:0];
                        extra_address_bit <= byte_mode ? req_addr[AW] : 1'b0;
                        select_n <= 1'b0;
                        select_hi <= 1'b1;
                        upper_lane_n <= byte_mode ? 1'b1 : ~req_lanes[1];
                        lower_lane_n <= byte_mode ? 1'b0 : ~req_lanes[0];
                        if (req_write) begin
                            write_n <= 1'b0;
                            out_gate_n <= 1'b1;
                            data_pins_out <= req_wdata;
                            data_pins_oe_n <= 1'b0;
                            cnt_q <= WR_CYC;
                            state_q <= ST_WRITE;
                        end else begin
                            data_pins_oe_n <= 1'b1;
                            out_gate_n <= 1'b0;
                            cnt_q <= RD_CYC;
                            state_q <= ST_READ;
                        end
                    end else if (req_valid) begin
                        rsp_valid <= 1'b1;
                    end
                end
                ST_READ: begin
                    if (cnt_q > 5'h01) begin
                        cnt_q <= cnt_q - 5'h01;
                    end else begin
                        // Two cycles pass before the sample: the pins settle through the synchroniser.
                        cnt_q <= 5'h00;
                        state_q <= ST_WEND;
                    end
                end
                ST_WRITE: begin
                    if (cnt_q > 5'h01) begin
                        cnt_q <= cnt_q - 5'h01;
                    end else begin
                        // Strobe ends first; data stays one more cycle for hold.
                        write_n <= 1'b1;
                        cnt_q <= (WC_CYC > WR_CYC) ? (WC_CYC - WR_CYC) : 5'h01;
                        state_q <= ST_WEND;
                    end
                end
                ST_WEND: begin
                    if (!write_n || !out_gate_n) begin
                        // Read path: hold two more cycles for the synchroniser delay.
                        if (cnt_q < 5'h02) begin
                            cnt_q <= cnt_q + 5'h01;
                        end else begin
                            rsp_rdata <= {upper_lane_n ? 8'h00 : din_s2_q[15:8],
                                          lower_lane_n ? 8'h00 : din_s2_q[7:0]};
                            rsp_valid <= 1'b1;
                            out_gate_n <= 1'b1;
                            select_n <= 1'b1;
                            select_hi <= 1'b0;
                            upper_lane_n <= 1'b1;
                            lower_lane_n <= 1'b1;
                            cnt_q <= HZ_CYC;
                            state_q <= ST_TURN;
                        end
                    end else begin
                        data_pins_oe_n <= 1'b1;
                        select_n <= 1'b1;
                        select_hi <= 1'b0;
                        upper_lane_n <= 1'b1;
                        lower_lane_n <= 1'b1;
                        rsp_valid <= 1'b1;
                        state_q <= ST_TURN;
                    end
                end
                ST_TURN: begin
                    // Bus turnaround: memory output float time after a read, the rest of the write cycle after a write.
                    if (cnt_q > 5'h01) begin
                        cnt_q <= cnt_q - 5'h01;
                    end else begin
                        cnt_q <= 5'h00;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // asrc_ctrl

/* File: asrc_consts.vh */
// Timing figures and derived cycle counts for the asynchronous SRAM controller.
// Assumes a 250 MHz ref_clk; counts round minimum times up, never below one cycle.
`ifndef ASRC_CONSTS_VH
`define ASRC_CONSTS_VH

`define ASRC_CLK_PS 4000
`define ASRC_T_RC_NS 70
`define ASRC_T_AA_NS 70
`define ASRC_T_DOE_NS 35
`define ASRC_T_HZ_NS 25
`define ASRC_T_WC_NS 70
`define ASRC_T_AW_NS 60
`define ASRC_T_PWE_NS 45
`define ASRC_T_SD_NS 30
`define ASRC_T_HD_NS 0
`define ASRC_T_SA_NS 0
`define ASRC_CYC(ns) ((((ns) * 1000) + `ASRC_CLK_PS - 1) / `ASRC_CLK_PS)
`define ASRC_ATLEAST1(c) (((c) < 1) ? 1 : (c))

`endif

/* File: asrc_sram_model.sv */
// Behavioural 16-bit asynchronous SRAM with byte lanes, standing at the controller's pins.
// Assumes split data pins; the model resolves the shared bus from both enables.
`timescale 1ns/1ps
module asrc_sram_model #(
    parameter AW = 21,
    parameter ACC = 70
) (
    input wire [AW-1:0] mem_addr,
    input wire extra_address_bit,
    input wire select_n, select_hi, write_n, out_gate_n, upper_lane_n, lower_lane_n,
    input wire [15:0] data_pins_out,
    input wire data_pins_oe_n,
    output logic [15:0] data_pins_in
);
    logic [15:0] mem [logic [AW:0]];
    logic [15:0] vis;
    logic [15:0] dly;
    wire [AW:0] key = {extra_address_bit, mem_addr};
    wire [15:0] lane = {{8{!upper_lane_n}}, {8{!lower_lane_n}}};
    // Both lane enables high deselects the part just as the chip selects do.
    wire sel = !select_n && select_hi && (lane != 16'h0000);
    always @(sel or write_n or key or lane or data_pins_out) begin
        if (sel && !write_n)
            mem[key] = (mem[key] & ~lane) | (data_pins_out & lane);
    end
    always @(sel or write_n or out_gate_n or key or lane or data_pins_out) begin
        if (sel && write_n && !out_gate_n)
            vis = (mem[key] & lane) | (~data_pins_out & ~lane);
        else
            vis = ~data_pins_out;
    end
    // Transport delay keeps stale data visible, so an early sample reads the wrong word.
    always @(vis) dly <= #ACC vis;
    assign data_pins_in = data_pins_oe_n ? dly : data_pins_out;
endmodule // asrc_sram_model

/* File: asrc_ctrl_props.sv */
// Timing checker for the asynchronous SRAM controller pins.
// Assumes it is bound into asrc_ctrl and sees only its ports.
`timescale 1ns/1ps
module asrc_ctrl_props #(
    parameter AW = 21
) (
    input logic ref_clk, rst_n, rsp_valid,
    input logic [AW-1:0] mem_addr,
    input logic select_n, select_hi, write_n, out_gate_n, upper_lane_n, lower_lane_n, data_pins_oe_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence low7_s(s); !s [*7]; endsequence
    AST_WR_QUAL: assert property ($fell(write_n) |-> !select_n && select_hi && !(upper_lane_n && lower_lane_n))
        else $error("write strobe fell without selects and a lane");
    AST_WR_LEN: assert property ($fell(write_n) |-> low7_s(write_n) ##1 low7_s(write_n) ##1 !write_n ##1 write_n)
        else $error("write strobe not low for 15 cycles");
    AST_ADDR_HOLD: assert property (!write_n && !$fell(write_n) |-> $stable(mem_addr))
        else $error("address moved during write");
    AST_DATA_HOLD: assert property ($rose(write_n) |-> !data_pins_oe_n ##1 data_pins_oe_n)
        else $error("write data not held one cycle past strobe");
    AST_NO_CLASH: assert property (!out_gate_n |-> data_pins_oe_n)
        else $error("controller drives while output gate is low");
    AST_SEL_VALID: assert property (select_n != select_hi)
        else $error("chip selects disagree");
    AST_RD_WAIT: assert property ($fell(out_gate_n) |-> low7_s(out_gate_n) ##1 low7_s(out_gate_n)
        ##1 low7_s(out_gate_n) ##1 rsp_valid)
        else $error("read answered at wrong cycle");
    AST_WR_END: assert property ($rose(write_n) |=> rsp_valid && select_n && !select_hi)
        else $error("write end not followed by deselect and response");
endmodule // asrc_ctrl_props
bind asrc_ctrl asrc_ctrl_props #(.AW(AW)) u_props (.ref_clk(ref_clk), .rst_n(rst_n), .rsp_valid(rsp_valid),
    .mem_addr(mem_addr), .select_n(select_n), .select_hi(select_hi), .write_n(write_n), .out_gate_n(out_gate_n),
    .upper_lane_n(upper_lane_n), .lower_lane_n(lower_lane_n), .data_pins_oe_n(data_pins_oe_n));

/* File: asrc_ctrl_bench.sv */
// Self-checking bench for asrc_ctrl against the behavioural SRAM model.
// Assumes a 250 MHz clock; expectations come from a shadow copy of memory.
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin miscompares++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module asrc_ctrl_bench;
    logic ref_clk = 0, rst_n = 0, byte_mode = 0, req_valid = 0, req_write = 0;
    logic [21:0] req_addr = 0, a;
    logic [1:0] req_lanes = 0;
    logic [15:0] req_wdata = 0, rsp_rdata, data_pins_in, data_pins_out, sh [logic [21:0]];
    logic [20:0] mem_addr;
    logic req_ready, rsp_valid, extra_address_bit, select_n, select_hi, write_n, out_gate_n;
    logic upper_lane_n, lower_lane_n, data_pins_oe_n;
    logic [16:0] notes [$], n;
    int miscompares = 0, num_checks = 0;
    always #2 ref_clk = ~ref_clk;
    asrc_ctrl dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .byte_mode(byte_mode), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_lanes(req_lanes), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr),
        .extra_address_bit(extra_address_bit), .select_n(select_n), .select_hi(select_hi), .write_n(write_n),
        .out_gate_n(out_gate_n), .upper_lane_n(upper_lane_n), .lower_lane_n(lower_lane_n),
        .data_pins_in(data_pins_in), .data_pins_out(data_pins_out), .data_pins_oe_n(data_pins_oe_n));
    asrc_sram_model mem_u (.mem_addr(mem_addr), .extra_address_bit(extra_address_bit), .select_n(select_n),
        .select_hi(select_hi), .write_n(write_n), .out_gate_n(out_gate_n), .upper_lane_n(upper_lane_n),
        .lower_lane_n(lower_lane_n), .data_pins_out(data_pins_out), .data_pins_oe_n(data_pins_oe_n),
        .data_pins_in(data_pins_in));
    task automatic close_out();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // A request is noted when it is taken; disabled lanes must read back as zero.
    task automatic op(input logic w, input logic [21:0] ad, input logic [1:0] ln, input logic [15:0] d);
        logic [15:0] m;
        m = {{8{ln[1]}}, {8{ln[0]}}};
        // One edge always passes, so a request never rises in the step where the last one fell.
        do @(posedge ref_clk) #1; while (req_ready !== 1'b1);
        req_valid = 1;
        req_write = w;
        req_addr = ad;
        req_lanes = ln;
        req_wdata = d;
        if (w)
            sh[ad] = (sh[ad] & ~m) | (d & m);
        notes.push_back({!w, sh[ad] & m});
        @(posedge ref_clk) #1;
        req_valid = 0;
    endtask
    always @(posedge ref_clk) begin
        if (rsp_valid === 1'b1) begin
            n = notes.pop_front();
            if (n[16])
                `CHK("rsp_rdata", n[15:0], rsp_rdata)
        end
    end
    initial begin
        #20000;
        miscompares++;
        close_out();
    end
    initial begin
        void'($urandom(64831));
        repeat (10) @(posedge ref_clk);
        #1 rst_n = 1;
        for (int i = 0; i < 9; i++) begin
            a = 22'($urandom % 32'h200000);
            op(1, a, 2'h3, 16'($urandom));
            op(1, a, 2'(i % 3 + 1), 16'($urandom));
            // No lane enabled: answered at once, and the following read proves nothing was stored.
            op(1, a, 2'h0, 16'($urandom));
            op(0, a, 2'(i / 3 + 1), 16'h0000);
        end
        wait (notes.size() == 0);
        @(posedge ref_clk) #1;
        // Byte mode high: the top address bit must split two otherwise equal words.
        byte_mode = 1;
        op(1, a | 22'h200000, 2'h1, 16'($urandom));
        op(1, a, 2'h1, 16'($urandom));
        op(0, a | 22'h200000, 2'h1, 16'h0000);
        op(0, a, 2'h1, 16'h0000);
        wait (notes.size() == 0);
        repeat (10) @(posedge ref_clk);
        close_out();
    end
endmodule // asrc_ctrl_bench
